// *** core/swc_sleep_wake.sv ***
// Function
// (R01) sleep instruction enters power-down unless interrupt pending
// (R02) entry clears watchdog, power-down flag; sets time-out; oscillator off
// (R03) port pins hold drive state while asleep
// (R04) wake on master clear, watchdog, enabled interrupt
// (R05) master clear resets; other wakes resume execution
// (R06) power-down set at power-up; watchdog wake clears time-out
// (R07) only clock-independent peripheral interrupts can wake
// (R08) entry prefetches next program address
// (R09) enabled source wakes regardless of global enable
// (R10) global enable picks in-line or vectored resume
// (R11) interrupt pending before sleep makes it a no-op
// (R12) interrupt during sleep execution completes entry, wakes
// (R13) crystal modes wait 1024 oscillator periods on wake
// (R14) watchdog timeout resets when awake, wakes when asleep
// (R15) vectoring clears global enable, pushes, loads vector
// (R16) two dummy cycles before first vector instruction
module swc_sleep_wake
   import swc_pkg::*;
#(
   parameter int WDT_TICK_DIV   = WDT_TICK_DIV_DEF,
   parameter int WDT_BASE_TICKS = WDT_BASE_TICKS_DEF
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // avalon-mm register slave
   input  wire logic [ADDR_W-1:0]     avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [DATA_W-1:0]     avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [DATA_W-1:0]     avs_readdata,
   output logic                       avs_waitrequest,
   // core instruction events
   input  wire logic                  sleepExec,
   input  wire logic                  clrwdtExec,
   input  wire logic                  retfieExec,
   input  wire logic                  instrDone,
   input  wire logic [PC_W-1:0]       pcIn,
   // interrupt flags from sources
   input  wire logic [IRQ_SRC_W-1:0]  irqFlag,
   // core control
   output logic                       coreRun,
   output logic                       coreReset,
   output logic                       pcLoad,
   output logic      [PC_W-1:0]       pcLoadAddr,
   output logic                       stackPush,
   output logic                       prefetchStrobe,
   output logic      [PC_W-1:0]       prefetchAddr,
   // pins and configuration
   input  wire logic                  masterClearPin_n,
   input  wire logic                  watchdogEnableFuse,
   input  wire logic                  crystalOsc,
   output logic                       oscDriverEn,
   // port drive hold
   input  wire logic [7:0]            portOutIn,
   input  wire logic [7:0]            portOeIn_n,
   output logic      [7:0]            portOut,
   output logic      [7:0]            portOe_n,
   // interrupt
   output logic                       irq
);

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   swc_state_t state;
   swc_state_t next_state;

   // register file
   logic [7:0]       timer_prescale_option;
   logic [IRQ_SRC_W-1:0] wakeEnable;
   logic             global_irq_enable;
   logic             power_down_flag;
   logic             time_out_flag;
   logic [EVT_W-1:0] evtStatus;
   logic [EVT_W-1:0] evtMask;

   // bus handshake
   logic             busAck;
   wire              busReq;
   wire              wrEn;
   wire              hitStatus;
   wire              hitOption;
   wire              hitCtrl;
   wire              hitWake;
   wire              hitEvent;
   wire              hitMask;
   wire  [7:0]       wrByte;
   logic [7:0]       readMux;

   // synchroniser for the reset pin
   logic             mclrMeta_n;
   logic             mclrSync_n;
   logic             mclrPrev;
   wire              mclrActive;

   // wake and sleep decisions
   wire              pendingWake;
   wire              sleepEnter;
   wire              sleepAsNop;
   wire              wdtTimeout;
   wire              wdtWake;
   wire              wdtRunReset;
   wire              irqWake;
   wire              wakeNow;
   wire              wdtClear;
   wire              holdPins;
   wire              vectorStart;
   logic             vecPending;
   wire              ostBusy;
   wire              ostDone;
   wire  [EVT_W-1:0] evtSet;
   wire  [EVT_W-1:0] evtClr;

   // address decode
   assign busReq    = avs_read || avs_write;
   assign hitStatus = hit(avs_address, IDX_STATUS);
   assign hitOption = hit(avs_address, IDX_OPTION);
   assign hitCtrl   = hit(avs_address, IDX_CTRL);
   assign hitWake   = hit(avs_address, IDX_WAKE_EN);
   assign hitEvent  = hit(avs_address, IDX_EVENT);
   assign hitMask   = hit(avs_address, IDX_MASK);
   assign wrEn      = avs_write && busAck && avs_byteenable[0];
   assign wrByte    = avs_writedata[7:0];

   // one wait cycle lets the read mux settle into a flop
   assign avs_waitrequest = busReq && !busAck;

   always_comb begin
      readMux = 8'h00;
      if (hitStatus) begin
         readMux[STAT_PD_BIT] = power_down_flag;
         readMux[STAT_TO_BIT] = time_out_flag;
      end else if (hitOption) begin
         readMux = timer_prescale_option;
      end else if (hitCtrl) begin
         readMux[CTRL_GIE_BIT] = global_irq_enable;
      end else if (hitWake) begin
         readMux = wakeEnable;
      end else if (hitEvent) begin
         readMux[EVT_W-1:0] = evtStatus;
      end else if (hitMask) begin
         readMux[EVT_W-1:0] = evtMask;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busAck       <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         busAck <= busReq && !busAck;
         if (avs_read && !busAck) begin
            avs_readdata <= {24'h00_0000, readMux};
         end
      end
   end

   // master clear pin, two flops before any use
   always_ff @(posedge clk) begin
      if (rst) begin
         mclrMeta_n <= 1'b1;
         mclrSync_n <= 1'b1;
         mclrPrev   <= 1'b0;
      end else begin
         mclrMeta_n <= masterClearPin_n;
         mclrSync_n <= mclrMeta_n;
         mclrPrev   <= mclrActive;
      end
   end

   assign mclrActive = !mclrSync_n;

   // only wake-capable sources are wired to irqFlag; clocked peripherals stay off it
   assign pendingWake = |(irqFlag & wakeEnable);                       // [R07] [R09]
   assign sleepEnter  = (state == ST_RUN) && sleepExec && !pendingWake
                        && !mclrActive;                                 // [R01]
   assign sleepAsNop  = (state == ST_RUN) && sleepExec && pendingWake;  // [R11]
   assign wdtWake     = (state == ST_SLEEP) && wdtTimeout;              // [R14]
   assign wdtRunReset = (state != ST_SLEEP) && wdtTimeout;              // [R14]
   // an interrupt raised while entering is seen on the first sleep cycle
   assign irqWake     = (state == ST_SLEEP) && pendingWake;             // [R12]
   assign wakeNow     = (wdtWake || irqWake) && !mclrActive;            // [R04]
   assign wdtClear    = sleepEnter || clrwdtExec || mclrActive;         // [R02]
   assign holdPins    = (state == ST_SLEEP) || (state == ST_START);
   assign vectorStart = (state == ST_RESUME) && instrDone && vecPending;

   swc_watchdog #(
      .TICK_DIV   (WDT_TICK_DIV),
      .BASE_TICKS (WDT_BASE_TICKS)
   ) u_watchdog (
      .clk          (clk),
      .rst          (rst),
      .enable       (watchdogEnableFuse),
      .clear        (wdtClear),
      .prescaleOn   (timer_prescale_option[OPT_PSA_BIT]),
      .prescaleRate (timer_prescale_option[OPT_RATE_HI:0]),
      .timeout      (wdtTimeout)
   );

   swc_osc_startup #(
      .CYCLES (OST_CYCLES)
   ) u_startup (
      .clk   (clk),
      .rst   (rst || mclrActive),
      .start (wakeNow && crystalOsc),                                   // [R13]
      .busy  (ostBusy),
      .done  (ostDone)
   );

   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (sleepEnter) begin
               next_state = ST_SLEEP;                                   // [R01]
            end
         end
         ST_SLEEP: begin
            if (wakeNow) begin
               next_state = crystalOsc ? ST_START : ST_RESUME;          // [R13]
            end
         end
         ST_START: begin
            if (ostDone) begin
               next_state = ST_RESUME;
            end
         end
         ST_RESUME: begin
            if (instrDone) begin
               next_state = vecPending ? ST_DUMMY1 : ST_RUN;            // [R10]
            end
         end
         ST_DUMMY1: begin
            next_state = ST_DUMMY2;                                     // [R16]
         end
         ST_DUMMY2: begin
            next_state = ST_RUN;                                        // [R16]
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
      if (mclrActive || wdtRunReset) begin
         next_state = ST_RUN;                                           // [R05]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // the vector decision is frozen at wake so a later enable write cannot change it
   always_ff @(posedge clk) begin
      if (rst || mclrActive || next_state == ST_RUN) begin
         vecPending <= 1'b0;
      end else if (irqWake) begin
         vecPending <= global_irq_enable;                               // [R10]
      end
   end

   // status flags
   always_ff @(posedge clk) begin
      if (rst) begin
         power_down_flag <= 1'b1;                                       // [R06]
         time_out_flag   <= 1'b1;
      end else if (sleepEnter) begin
         power_down_flag <= 1'b0;                                       // [R02]
         time_out_flag   <= 1'b1;                                       // [R02]
      end else if (wdtWake) begin
         time_out_flag   <= 1'b0;                                       // [R06]
      end else if (wdtRunReset) begin
         time_out_flag   <= 1'b0;
         power_down_flag <= 1'b1;
      end else if (clrwdtExec) begin
         time_out_flag   <= 1'b1;
         power_down_flag <= 1'b1;
      end
   end

   // software registers
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_prescale_option <= OPTION_RST;
         wakeEnable            <= WAKE_EN_RST;
         evtMask               <= EVT_RST;
      end else if (wrEn) begin
         if (hitOption) begin
            timer_prescale_option <= wrByte;
         end
         if (hitWake) begin
            wakeEnable <= wrByte;
         end
         if (hitMask) begin
            evtMask <= wrByte[EVT_W-1:0];
         end
      end
   end

   // hardware clear on vectoring beats a software set in the same cycle
   always_ff @(posedge clk) begin
      if (rst || mclrActive || wdtRunReset) begin
         global_irq_enable <= 1'b0;
      end else if (vectorStart) begin
         global_irq_enable <= 1'b0;                                     // [R15]
      end else if (wrEn && hitCtrl) begin
         global_irq_enable <= wrByte[CTRL_GIE_BIT];
      end else if (retfieExec) begin
         global_irq_enable <= 1'b1;
      end
   end

   // sticky events, write one to clear, a new event wins over the clear
   assign evtSet[EVT_SLEEP_BIT]   = sleepEnter;
   assign evtSet[EVT_IRQWAKE_BIT] = irqWake && !mclrActive;
   assign evtSet[EVT_WDTWAKE_BIT] = wdtWake && !mclrActive;
   assign evtSet[EVT_WDTRST_BIT]  = wdtRunReset;
   assign evtSet[EVT_MASTER_CLEAR_PIN_BIT]    = mclrActive && !mclrPrev;
   assign evtClr = (wrEn && hitEvent) ? wrByte[EVT_W-1:0] : EVT_RST;

   always_ff @(posedge clk) begin
      if (rst) begin
         evtStatus <= EVT_RST;
      end else begin
         evtStatus <= (evtStatus & ~evtClr) | evtSet;
      end
   end

   assign irq = |(evtStatus & evtMask);

   // core control
   assign coreRun = ((state == ST_RUN) || (state == ST_RESUME)) && !coreReset;

   always_ff @(posedge clk) begin
      if (rst) begin
         coreReset <= 1'b1;
      end else begin
         coreReset <= mclrActive || wdtRunReset;                        // [R05] [R14]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         oscDriverEn <= 1'b1;
      end else if (sleepEnter) begin
         oscDriverEn <= 1'b0;                                           // [R02]
      end else if (wakeNow || mclrActive) begin
         oscDriverEn <= 1'b1;                                           // [R05]
      end
   end

   // vector load: pulse on entry to the first dummy cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pcLoad     <= 1'b0;
         stackPush  <= 1'b0;
         pcLoadAddr <= 13'h0000;
      end else begin
         pcLoad    <= vectorStart && !mclrActive;                       // [R15]
         stackPush <= vectorStart && !mclrActive;                       // [R15]
         if (vectorStart) begin
            pcLoadAddr <= VECTOR_ADDR;                                  // [R15]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prefetchStrobe <= 1'b0;
         prefetchAddr   <= 13'h0000;
      end else begin
         prefetchStrobe <= sleepEnter;                                  // [R08]
         if (sleepEnter) begin
            prefetchAddr <= pcIn + 13'h0001;                            // [R08]
         end
      end
   end

   // pins keep their drive until execution resumes
   always_ff @(posedge clk) begin
      if (rst) begin
         portOut  <= 8'h00;
         portOe_n <= 8'hff;
      end else if (!holdPins) begin
         portOut  <= portOutIn;                                         // [R03]
         portOe_n <= portOeIn_n;                                        // [R03]
      end
   end

endmodule

// *** inc/swc_pkg.sv ***
package swc_pkg;

   // clock and oscillator timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int OSC_PERIOD_PS = 25000;
   localparam int OST_PERIODS   = 1024;
   localparam int OST_CYCLES    =
      (OST_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // watchdog timing defaults
   localparam int WDT_TICK_DIV_DEF   = 40;
   localparam int WDT_BASE_TICKS_DEF = 18000;

   // bus geometry: byte address is four times the register index
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int PC_W   = 13;

   // register indices
   localparam logic [7:0] IDX_STATUS  = 8'h03;
   localparam logic [7:0] IDX_OPTION  = 8'h81;
   localparam logic [7:0] IDX_CTRL    = 8'h90;
   localparam logic [7:0] IDX_WAKE_EN = 8'h91;
   localparam logic [7:0] IDX_EVENT   = 8'h92;
   localparam logic [7:0] IDX_MASK    = 8'h93;

   // field positions
   localparam int STAT_PD_BIT     = 3;
   localparam int STAT_TO_BIT     = 4;
   localparam int OPT_PSA_BIT     = 3;
   localparam int OPT_RATE_HI     = 2;
   localparam int CTRL_GIE_BIT    = 0;
   localparam int EVT_SLEEP_BIT   = 0;
   localparam int EVT_IRQWAKE_BIT = 1;
   localparam int EVT_WDTWAKE_BIT = 2;
   localparam int EVT_WDTRST_BIT  = 3;
   localparam int EVT_MASTER_CLEAR_PIN_BIT    = 4;
   localparam int EVT_W           = 5;
   localparam int IRQ_SRC_W       = 8;

   // values after reset
   localparam logic [7:0]       OPTION_RST  = 8'hff;
   localparam logic [7:0]       WAKE_EN_RST = 8'h00;
   localparam logic [EVT_W-1:0] EVT_RST     = 5'h00;

   // interrupt vector
   localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;

   typedef enum logic [2:0] {
      ST_RUN    = 3'b000,
      ST_SLEEP  = 3'b001,
      ST_START  = 3'b010,
      ST_RESUME = 3'b011,
      ST_DUMMY1 = 3'b100,
      ST_DUMMY2 = 3'b101
   } swc_state_t;

endpackage

// *** core/swc_osc_startup.sv ***
module swc_osc_startup
   import swc_pkg::*;
#(
   parameter int CYCLES = OST_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic start,
   output logic      busy,
   output logic      done
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count;

   if (CYCLES < 1) begin : g_chk
      $error("startup delay must be at least one cycle");
   end

   assign done = busy && (count == CW'(CYCLES - 1));

   always_ff @(posedge clk) begin
      if (rst || done) begin
         busy  <= 1'b0;
         count <= '0;
      end else if (start) begin
         busy  <= 1'b1;
         count <= '0;
      end else if (busy) begin
         count <= count + CW'(1);
      end
   end

endmodule

// *** core/swc_watchdog.sv ***
module swc_watchdog
   import swc_pkg::*;
#(
   parameter int TICK_DIV   = WDT_TICK_DIV_DEF,
   parameter int BASE_TICKS = WDT_BASE_TICKS_DEF
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       enable,
   input  wire logic       clear,
   input  wire logic       prescaleOn,
   input  wire logic [2:0] prescaleRate,
   // event
   output logic            timeout
);

   localparam int DW = $clog2(TICK_DIV + 1);
   localparam int BW = $clog2(BASE_TICKS + 1);

   logic [DW-1:0] divCount;
   logic [BW-1:0] baseCount;
   logic [7:0]    postCount;
   wire           tick;
   wire           baseWrap;
   wire  [7:0]    postTarget;

   if (TICK_DIV < 1 || BASE_TICKS < 2) begin : g_chk
      $error("watchdog divider or period out of range");
   end

   // stands in for the free-running rc clock: one enable pulse per tick
   assign tick       = enable && (divCount == DW'(TICK_DIV - 1));
   assign baseWrap   = tick && (baseCount == BW'(BASE_TICKS - 1));
   assign postTarget = prescaleOn ? ((8'h01 << prescaleRate) - 8'h01) : 8'h00;
   assign timeout    = baseWrap && (postCount == postTarget);

   always_ff @(posedge clk) begin
      if (rst || clear || !enable || tick) begin
         divCount <= '0;
      end else begin
         divCount <= divCount + DW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clear || !enable) begin
         baseCount <= '0;
         postCount <= 8'h00;
      end else if (baseWrap) begin
         baseCount <= '0;
         postCount <= timeout ? 8'h00 : postCount + 8'h01;
      end else if (tick) begin
         baseCount <= baseCount + BW'(1);
      end
   end

endmodule

// *** tb/swc_irq_source.sv ***
module swc_irq_source
   import swc_pkg::*;
(
   // clock
   input  wire logic                 clk,
   // requests from the bench
   input  wire logic [IRQ_SRC_W-1:0] irqReq,
   input  wire logic                 mclrReq,
   // device pins
   output logic      [IRQ_SRC_W-1:0] irqFlag,
   output logic                      masterClearPin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // clock-free sources only
   always @(posedge clk) begin
      irqFlag          <= irqReq;   // level until serviced
      masterClearPin_n <= !mclrReq; // pin idles high
   end
endmodule

// *** tb/swc_sleep_wake_properties.sv ***
module swc_sleep_wake_properties
   import swc_pkg::*;
(
   // clock and reset
   input logic                 clk,
   input logic                 rst,
   // register bus
   input logic                 avs_read,
   input logic                 avs_write,
   input logic [DATA_W-1:0]    avs_readdata,
   input logic                 avs_waitrequest,
   // core side
   input logic                 sleepExec,
   input logic [PC_W-1:0]      pcIn,
   input logic [IRQ_SRC_W-1:0] irqFlag,
   input logic                 coreRun,
   input logic                 coreReset,
   input logic                 pcLoad,
   input logic [PC_W-1:0]      pcLoadAddr,
   input logic                 stackPush,
   input logic                 prefetchStrobe,
   input logic [PC_W-1:0]      prefetchAddr,
   // pins
   input logic                 masterClearPin_n,
   input logic                 crystalOsc,
   input logic                 oscDriverEn,
   input logic [7:0]           portOut,
   input logic [7:0]           portOe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // no flag, so sleep cannot be a no-op
   wire entryOk = sleepExec && coreRun && oscDriverEn && !coreReset
                  && irqFlag == '0 && masterClearPin_n;
   wire busReq  = avs_read || avs_write;

   sleep_entry_a: assert property (entryOk |=> !oscDriverEn && prefetchStrobe)
      else $error("sleep entry not taken");
   prefetch_addr_a: assert property (entryOk |=> prefetchAddr == $past(pcIn) + 13'h0001)
      else $error("prefetch address wrong");
   port_hold_a: assert property (!oscDriverEn && $past(!oscDriverEn) |->
      $stable(portOut) && $stable(portOe_n)) else $error("port drive moved in sleep");
   vector_load_a: assert property (pcLoad |-> stackPush && pcLoadAddr == VECTOR_ADDR)
      else $error("vector load wrong");
   dummy_cycles_a: assert property (pcLoad |-> !coreRun ##1 !coreRun ##1 coreRun)
      else $error("dummy cycles wrong");
   master_clear_pin_reset_a: assert property (!masterClearPin_n [*4] |-> coreReset && !coreRun)
      else $error("master clear not resetting");
   rc_resume_a: assert property (masterClearPin_n [*4] ##0 ($rose(oscDriverEn)
      && !crystalOsc) |-> coreRun) else $error("rc wake delayed");
   bus_wait_a: assert property (busReq && !$past(busReq) |-> avs_waitrequest ##1
      !avs_waitrequest) else $error("bus wait cycle wrong");
   read_upper_a: assert property (avs_read && !avs_waitrequest |->
      avs_readdata[31:8] == 24'h00_0000) else $error("read upper bits set");
endmodule

bind swc_sleep_wake swc_sleep_wake_properties u_props (.*);

// *** tb/swc_sleep_wake_tb.sv ***
module swc_sleep_wake_tb
   import swc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [ADDR_W-1:0] avs_address;
   logic [DATA_W-1:0] avs_writedata, avs_readdata;
   logic              sleepExec, clrwdtExec, retfieExec, instrDone, mclrReq;
   logic [PC_W-1:0]   pcIn, pcLoadAddr, prefetchAddr;
   logic [7:0]        irqReq, irqFlag, portOutIn, portOeIn_n, portOut, portOe_n;
   logic              coreRun, coreReset, pcLoad, stackPush, prefetchStrobe, irq;
   logic              masterClearPin_n, watchdogEnableFuse, crystalOsc, oscDriverEn;
   int                miscompares, n_compared;

   // short watchdog: 16 cycles, postscaler off
   swc_sleep_wake #(.WDT_TICK_DIV(2), .WDT_BASE_TICKS(8)) dut (.*, .avs_byteenable(4'h1));
   swc_irq_source src (.*);

   always #12.5 clk = !clk;

   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic tmo();
      miscompares++;
      results();
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= {i, 2'b00};
      avs_read      <= !w;
      avs_write     <= w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) tmo();
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask
   task automatic rd(input logic [7:0] i, output logic [31:0] q);
      bus(1'b0, i, 32'h0000_0000, q);
   endtask
   // 0 sleep, 1 wdt clear, 2 return, 3 done
   task automatic pulse(input int s);
      @(posedge clk);
      case (s)
         0: sleepExec <= 1'b1;
         1: clrwdtExec <= 1'b1;
         2: retfieExec <= 1'b1;
         default: instrDone <= 1'b1;
      endcase
      @(posedge clk);
      {sleepExec, clrwdtExec, retfieExec, instrDone} <= 4'h0;
      @(negedge clk);
   endtask
   // 0 run, 1 vector load, 2 reset
   task automatic waitSig(input int s, input int lim, output int n);
      n = 0;
      while (n < lim && !(s == 0 ? coreRun === 1'b1 : s == 1 ? pcLoad === 1'b1
                          : coreReset === 1'b1)) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) tmo();
   endtask
   task automatic irqPulse(input logic [7:0] v, input int lim, output int n);
      @(posedge clk);
      irqReq <= v;
      waitSig(0, lim, n);
      @(posedge clk);
      irqReq <= 8'h00;
   endtask

   task automatic t_regs();
      logic [31:0] q;
      rd(IDX_STATUS, q);
      chk("status", q & 32'h0000_0018, 32'h0000_0018);
      wr(IDX_STATUS, 32'h0000_0000);
      rd(IDX_STATUS, q);
      chk("status ro", q & 32'h0000_0018, 32'h0000_0018);
      rd(IDX_OPTION, q);
      chk("option", q, {24'h00_0000, OPTION_RST});
      rd(8'h55, q);
      chk("unmapped", q, 32'h0000_0000);
   endtask
   task automatic t_noop();
      logic [31:0] q;
      wr(IDX_WAKE_EN, 32'h0000_00ff);
      irqReq <= 8'h02;
      pulse(0);
      chk("noop osc", oscDriverEn, 1'b1);
      rd(IDX_STATUS, q);
      chk("noop flags", q & 32'h0000_0018, 32'h0000_0018);
      irqReq <= 8'h00;
   endtask
   task automatic t_inline();
      logic [31:0] q;
      int          n;
      portOutIn  <= 8'ha5;
      portOeIn_n <= 8'h0f;
      pcIn       <= 13'h0123;
      pulse(0);
      chk("osc off", oscDriverEn, 1'b0);
      chk("prefetch", {prefetchStrobe, prefetchAddr}, 14'h2124);
      rd(IDX_STATUS, q);
      chk("sleep flags", q & 32'h0000_0018, 32'h0000_0010);
      portOutIn  <= 8'h5a;
      portOeIn_n <= 8'hf0;
      repeat (3) @(negedge clk);
      chk("port held", {portOe_n, portOut}, 16'h0fa5);
      irqPulse(8'h04, 20, n);
      chk("rc wake", n < 4, 1'b1);
      pulse(3);
      repeat (4) begin
         @(negedge clk);
         chk("in line", {coreRun, pcLoad}, 2'b10);
      end
   endtask
   task automatic t_vector();
      logic [31:0] q;
      int          n;
      pulse(2);
      pulse(0);
      irqPulse(8'h01, 20, n);
      pulse(3);
      waitSig(1, 4, n);
      chk("vector", {stackPush, pcLoadAddr}, {1'b1, VECTOR_ADDR});
      @(negedge clk);
      chk("dummy", coreRun, 1'b0);
      rd(IDX_CTRL, q);
      chk("gie clr", q[0], 1'b0);
   endtask
   task automatic t_crystal();
      int n;
      @(posedge clk);
      crystalOsc <= 1'b1;
      pulse(0);
      irqPulse(8'h01, 1100, n);
      chk("start delay", n >= OST_CYCLES, 1'b1);
      crystalOsc <= 1'b0;
      pulse(3);
   endtask
   task automatic t_wdt();
      logic [31:0] q;
      int          n;
      wr(IDX_OPTION, 32'h0000_0000);
      watchdogEnableFuse <= 1'b1;
      pulse(1);
      pulse(0);
      waitSig(0, 200, n);
      rd(IDX_STATUS, q);
      chk("wdt wake", q & 32'h0000_0018, 32'h0000_0000);
      pulse(3);
      waitSig(2, 200, n);
      @(posedge clk);
      watchdogEnableFuse <= 1'b0;
      rd(IDX_STATUS, q);
      chk("wdt reset", q & 32'h0000_0018, 32'h0000_0008);
   endtask
   task automatic t_master_clear_pin();
      logic [31:0] q;
      int          n;
      pulse(0);
      @(posedge clk);
      mclrReq <= 1'b1;
      waitSig(2, 10, n);
      @(posedge clk);
      mclrReq <= 1'b0;
      rd(IDX_EVENT, q);
      chk("master_clear_pin event", {oscDriverEn, q[4]}, 2'b11);
   endtask
   task automatic t_irq();
      logic [31:0] q;
      @(negedge clk);
      chk("masked", irq, 1'b0);
      wr(IDX_MASK, 32'h0000_0001);
      @(negedge clk);
      chk("irq up", irq, 1'b1);
      wr(IDX_EVENT, 32'h0000_001f);
      @(negedge clk);
      chk("irq clr", irq, 1'b0);
      rd(IDX_EVENT, q);
      chk("events", q, 32'h0000_0000);
   endtask

   initial begin
      {clk, sleepExec, clrwdtExec, retfieExec, instrDone, mclrReq} = '0;
      {avs_read, avs_write, watchdogEnableFuse, crystalOsc} = '0;
      {avs_address, avs_writedata, pcIn, irqReq, portOutIn} = '0;
      portOeIn_n  = 8'hff;
      miscompares = 0;
      n_compared  = 0;
      rst         = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_noop();
      t_inline();
      t_vector();
      t_crystal();
      t_wdt();
      t_master_clear_pin();
      t_irq();
      results();
   end
endmodule
